// File: fsp_pkg.sv
// package for the flash self program sequencer: register map, fields, geometry, timing
package fsp_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_OP_CONTROL = 8'h00;
  localparam logic [7:0] OFF_ADDR_LOW = 8'h04;
  localparam logic [7:0] OFF_ADDR_UPPER = 8'h08;
  localparam logic [7:0] OFF_UNLOCK_KEY = 8'h0C;
  localparam logic [7:0] OFF_LATCH_DATA = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  // flash_op_control fields
  localparam int CTL_START_BIT = 15;
  localparam int CTL_ERASE_BIT = 6;
  localparam int CTL_MTYPE_BIT = 4;
  localparam int CTL_BLOCK_LSB = 0;
  localparam int CTL_BLOCK_W = 4;
  // table write side selector in latch data word
  localparam int LAT_HIGH_BIT = 31;
  // key values
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  // geometry
  localparam int ROW_WORDS = 32;
  localparam int ROW_BYTES = 96;
  localparam int PANEL_ROWS = 128;
  localparam int GROUP_WORDS = 4;
  localparam int HIGH_WRITES = 4;
  // reset values
  localparam logic [15:0] RST_OP_CONTROL = 16'h0000;
  localparam logic [15:0] RST_ADDR_LOW = 16'h0000;
  localparam logic [7:0] RST_ADDR_UPPER = 8'h00;
  // table write takes two instruction cycles
  localparam int TBL_WRITE_CYCLES = 2;
  // flash array cycle time per operation, in ns
  localparam int ERASE_TIME_NS = 2000;
  localparam int PROG_TIME_NS = 1000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int ERASE_CYCLES = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {KEY_IDLE, KEY_HALF, KEY_ARMED} fsp_key_t;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_ERASE, SEQ_PROG} fsp_seq_t;
endpackage : fsp_pkg

// File: fsp_sequencer.sv
// flash self program sequencer with axi4-lite register slave
// Contract
// - rows of 32 instructions, erase one row
// - panels of 128 rows of instructions
// - program four instruction words per operation
// - latches hold 32 words, filled first
// - table write completes in two cycles
// - each row needs own started cycle
// - control selects blocks, type, starts cycle; block and type fields are stored but never decoded
// - low address captures effective address 15:0
// - upper address captures effective address 23:16
// - key write-only, 0x55 then 0xAA
// - address registers writable directly by software
// - flash usable during normal operation
//
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
module fsp_sequencer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic tbl_wr_valid,
  input wire logic tbl_wr_high,
  input wire logic [23:0] tbl_wr_ea,
  input wire logic [15:0] tbl_wr_data,
  output logic tbl_wr_done,
  output logic flash_we,
  output logic flash_erase,
  output logic [23:0] flash_addr,
  output logic [23:0] flash_wdata,
  output logic flash_busy
);
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] ERASE_CNT = CNT_W'(fsp_pkg::ERASE_CYCLES);
  localparam logic [CNT_W-1:0] PROG_CNT = CNT_W'(fsp_pkg::PROG_CYCLES);
  localparam logic [4:0] LAST_WORD = 5'(fsp_pkg::ROW_WORDS - 1);
  localparam logic [4:0] GRP_LAST = 5'(fsp_pkg::GROUP_WORDS - 1);

  logic [23:0] latch_r [fsp_pkg::ROW_WORDS];
  logic [15:0] op_control_r;
  logic [15:0] addr_low_r;
  logic [7:0] addr_upper_r;
  fsp_pkg::fsp_key_t key_r;
  fsp_pkg::fsp_seq_t seq_r;
  logic [CNT_W-1:0] cnt_r;
  logic [4:0] word_r;
  logic [5:0] low_cnt_r;
  logic [2:0] high_cnt_r;
  logic tbl_busy_r;
  logic err_r;
  logic [7:0] aw_addr_r;
  logic aw_have_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic w_have_r;
  logic wr_fire;
  logic start_req;
  logic tbl_take;

  // byte-lane merge used by the control and low address registers
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : merge16

  assign wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;
  assign start_req = wr_fire && aw_addr_r == fsp_pkg::OFF_OP_CONTROL && w_strb_r[1]
                     && w_data_r[fsp_pkg::CTL_START_BIT];
  // a request still held while its done pulse stands must not be taken a second time
  assign tbl_take = tbl_wr_valid && !tbl_busy_r && !tbl_wr_done && seq_r == fsp_pkg::SEQ_IDLE;

  // write address and data accepted independently, held until the response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      aw_addr_r <= 8'h00;
      s_axi_awready <= 1'b0;
    end else if (wr_fire) begin
      aw_have_r <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_have_r && !s_axi_bvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      s_axi_wready <= 1'b0;
    end else if (wr_fire) begin
      w_have_r <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_r <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_have_r && !s_axi_bvalid;
    end
  end

  // write response; unmapped offsets and status writes answer slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= fsp_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      unique case (aw_addr_r)
        fsp_pkg::OFF_OP_CONTROL, fsp_pkg::OFF_ADDR_LOW, fsp_pkg::OFF_ADDR_UPPER,
        fsp_pkg::OFF_UNLOCK_KEY, fsp_pkg::OFF_LATCH_DATA: s_axi_bresp <= fsp_pkg::RESP_OKAY;
        default: s_axi_bresp <= fsp_pkg::RESP_SLVERR;
      endcase
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // unlock key: any write other than the expected one drops the armed state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      key_r <= fsp_pkg::KEY_IDLE;
    end else if (wr_fire) begin
      if (aw_addr_r == fsp_pkg::OFF_UNLOCK_KEY && w_strb_r[0] && w_data_r[7:0] == fsp_pkg::KEY_FIRST) begin
        key_r <= fsp_pkg::KEY_HALF;
      end else if (aw_addr_r == fsp_pkg::OFF_UNLOCK_KEY && w_strb_r[0] && key_r == fsp_pkg::KEY_HALF
                   && w_data_r[7:0] == fsp_pkg::KEY_SECOND) begin
        key_r <= fsp_pkg::KEY_ARMED;
      end else begin
        key_r <= fsp_pkg::KEY_IDLE;
      end
    end
  end

  // control register; start bit self clears when the cycle ends
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      op_control_r <= fsp_pkg::RST_OP_CONTROL;
    end else if (seq_r != fsp_pkg::SEQ_IDLE && cnt_r == '0 && (seq_r == fsp_pkg::SEQ_ERASE || word_r == LAST_WORD)) begin
      op_control_r[fsp_pkg::CTL_START_BIT] <= 1'b0;
    end else if (wr_fire && aw_addr_r == fsp_pkg::OFF_OP_CONTROL && seq_r == fsp_pkg::SEQ_IDLE) begin
      op_control_r <= merge16(op_control_r, w_data_r, w_strb_r);
      op_control_r[fsp_pkg::CTL_START_BIT] <= start_req && key_r == fsp_pkg::KEY_ARMED;
    end
  end

  // address registers: captured from table writes or written by software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addr_low_r <= fsp_pkg::RST_ADDR_LOW;
      addr_upper_r <= fsp_pkg::RST_ADDR_UPPER;
    end else if (tbl_take) begin
      addr_low_r <= tbl_wr_ea[15:0];
      addr_upper_r <= tbl_wr_ea[23:16];
    end else if (wr_fire && seq_r == fsp_pkg::SEQ_IDLE) begin
      if (aw_addr_r == fsp_pkg::OFF_ADDR_LOW) begin
        addr_low_r <= merge16(addr_low_r, w_data_r, w_strb_r);
      end
      if (aw_addr_r == fsp_pkg::OFF_ADDR_UPPER && w_strb_r[0]) begin
        addr_upper_r <= w_data_r[7:0];
      end
    end
  end

  // table write into the latches, two cycles each; word index from the low address bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tbl_busy_r <= 1'b0;
      tbl_wr_done <= 1'b0;
      low_cnt_r <= 6'h00;
      high_cnt_r <= 3'h0;
    end else begin
      tbl_wr_done <= tbl_busy_r;
      tbl_busy_r <= tbl_take;
      if (tbl_take) begin
        if (tbl_wr_high) begin
          latch_r[tbl_wr_ea[5:1]][23:16] <= tbl_wr_data[7:0];
          high_cnt_r <= high_cnt_r + 3'h1;
        end else begin
          latch_r[tbl_wr_ea[5:1]][15:0] <= tbl_wr_data;
          low_cnt_r <= low_cnt_r + 6'h01;
        end
      end else if (seq_r != fsp_pkg::SEQ_IDLE) begin
        low_cnt_r <= 6'h00;
        high_cnt_r <= 3'h0;
      end
    end
  end

  // sequencer: erase one row, or program the row four words per operation
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seq_r <= fsp_pkg::SEQ_IDLE;
      cnt_r <= '0;
      word_r <= 5'h00;
      err_r <= 1'b0;
      flash_we <= 1'b0;
      flash_erase <= 1'b0;
      flash_addr <= 24'h000000;
      flash_wdata <= 24'h000000;
      flash_busy <= 1'b0;
    end else begin
      flash_we <= 1'b0;
      flash_erase <= 1'b0;
      unique case (seq_r)
        fsp_pkg::SEQ_IDLE: begin
          flash_busy <= 1'b0;
          word_r <= 5'h00;
          if (start_req && key_r == fsp_pkg::KEY_ARMED) begin
            flash_busy <= 1'b1;
            err_r <= 1'b0;
            if (w_data_r[fsp_pkg::CTL_ERASE_BIT]) begin
              seq_r <= fsp_pkg::SEQ_ERASE;
              cnt_r <= ERASE_CNT;
              flash_erase <= 1'b1;
              flash_addr <= {addr_upper_r, addr_low_r[15:6], 6'h00};
            end else begin
              seq_r <= fsp_pkg::SEQ_PROG;
              cnt_r <= PROG_CNT;
            end
          end else if (start_req) begin
            err_r <= 1'b1;
          end
        end
        fsp_pkg::SEQ_ERASE: begin
          cnt_r <= cnt_r - 1'b1;
          if (cnt_r == '0) begin
            seq_r <= fsp_pkg::SEQ_IDLE;
            flash_busy <= 1'b0;
          end
        end
        fsp_pkg::SEQ_PROG: begin
          // a word goes out each cycle of a group; the array time is paid once per group
          flash_we <= cnt_r == PROG_CNT;
          flash_addr <= {addr_upper_r, addr_low_r[15:6], word_r, 1'b0};
          flash_wdata <= latch_r[word_r];
          if ((word_r & GRP_LAST) != GRP_LAST) begin
            word_r <= word_r + 5'h01;
          end else begin
            cnt_r <= cnt_r - 1'b1;
            if (cnt_r == '0) begin
              cnt_r <= PROG_CNT;
              if (word_r == LAST_WORD) begin
                seq_r <= fsp_pkg::SEQ_IDLE;
                flash_busy <= 1'b0;
              end else begin
                word_r <= word_r + 5'h01;
              end
            end
          end
        end
      endcase
    end
  end

  // read channel; key register reads zero since it is write-only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= fsp_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= fsp_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        fsp_pkg::OFF_OP_CONTROL: s_axi_rdata <= {16'h0000, op_control_r};
        fsp_pkg::OFF_ADDR_LOW: s_axi_rdata <= {16'h0000, addr_low_r};
        fsp_pkg::OFF_ADDR_UPPER: s_axi_rdata <= {24'h000000, addr_upper_r};
        fsp_pkg::OFF_UNLOCK_KEY: s_axi_rdata <= 32'h0000_0000;
        fsp_pkg::OFF_LATCH_DATA: s_axi_rdata <= 32'h0000_0000;
        fsp_pkg::OFF_STATUS: s_axi_rdata <= {16'h0000, 1'b0, high_cnt_r, 2'h0, low_cnt_r,
                                              key_r == fsp_pkg::KEY_ARMED, err_r, 1'b0, flash_busy};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= fsp_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end
endmodule : fsp_sequencer

// File: fsp_sequencer_properties.sv
// port checker for the flash self program sequencer
module fsp_sequencer_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [31:0] s_axi_rdata,
  input wire logic tbl_wr_valid,
  input wire logic tbl_wr_done,
  input wire logic flash_we,
  input wire logic flash_erase,
  input wire logic [23:0] flash_addr,
  input wire logic flash_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // latch writes answer two cycles after the request, as a single pulse
  a_done_two_cycles: assert property (tbl_wr_done |-> $past(tbl_wr_valid, 2))
    else $error("table write done without request two cycles before");
  a_done_one_pulse: assert property (tbl_wr_done |=> !tbl_wr_done)
    else $error("table write done longer than one cycle");
  // erase always targets a whole row
  a_erase_row_base: assert property (flash_erase |-> flash_addr[5:0] == 6'h00)
    else $error("erase address not on a row boundary");
  a_erase_not_prog: assert property (flash_erase |-> !flash_we)
    else $error("erase and program strobes together");
  a_erase_busy: assert property (flash_erase |=> flash_busy)
    else $error("erase started without busy");
  a_erase_from_idle: assert property (flash_erase |-> !$past(flash_busy))
    else $error("erase started inside another cycle");
  a_prog_in_busy: assert property (flash_we |-> flash_busy)
    else $error("program strobe outside a cycle");
  // the key register never gives back what was written
  a_key_reads_zero: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr == fsp_pkg::OFF_UNLOCK_KEY |=> s_axi_rdata == 32'h00000000)
    else $error("key register read back nonzero");
  c_tbl_done: cover property (tbl_wr_done);
  c_erase: cover property (flash_erase);
  c_prog: cover property (flash_we ##1 flash_we);
endmodule : fsp_sequencer_checker

bind fsp_sequencer fsp_sequencer_checker u_chk (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready,
  .s_axi_araddr, .s_axi_rdata, .tbl_wr_valid, .tbl_wr_done, .flash_we, .flash_erase, .flash_addr, .flash_busy);

// File: fsp_core_model.sv
// core model that issues table writes into the panel write latches
module fsp_core_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic go,
  input wire logic go_high,
  input wire logic [23:0] go_ea,
  input wire logic [15:0] go_data,
  input wire logic tbl_wr_done,
  output logic tbl_wr_valid,
  output logic tbl_wr_high,
  output logic [23:0] tbl_wr_ea,
  output logic [15:0] tbl_wr_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // request held until done; released address and data lines are inverted so stale values never look valid
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tbl_wr_valid <= 1'b0;
      tbl_wr_high <= 1'b0;
      tbl_wr_ea <= 24'h000000;
      tbl_wr_data <= 16'h0000;
    end else if (tbl_wr_valid && tbl_wr_done) begin
      tbl_wr_valid <= 1'b0;
      tbl_wr_ea <= ~tbl_wr_ea;
      tbl_wr_data <= ~tbl_wr_data;
    end else if (go && !tbl_wr_valid) begin
      tbl_wr_valid <= 1'b1;
      tbl_wr_high <= go_high;
      tbl_wr_ea <= go_ea;
      tbl_wr_data <= go_data;
    end
  end
endmodule : fsp_core_model

// File: flash_self_program_sequencer_tb.sv
// self-checking bench for the flash self program sequencer
module flash_self_program_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, go = 1'b0, go_high = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata, rdat, first_d;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [23:0] go_ea = 24'h000000, tbl_wr_ea, flash_addr, flash_wdata, first_a, er_a;
  logic [15:0] go_data = 16'h0000, tbl_wr_data;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, tbl_wr_valid, tbl_wr_high;
  logic tbl_wr_done, flash_we, flash_erase, flash_busy;
  int failures = 0, checks_done = 0, n_we = 0, n_er = 0;
  fsp_sequencer uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tbl_wr_valid, .tbl_wr_high,
    .tbl_wr_ea, .tbl_wr_data, .tbl_wr_done, .flash_we, .flash_erase, .flash_addr, .flash_wdata, .flash_busy);
  fsp_core_model core (.aclk, .aresetn, .go, .go_high, .go_ea, .go_data, .tbl_wr_done, .tbl_wr_valid,
    .tbl_wr_high, .tbl_wr_ea, .tbl_wr_data);
  // free running clock
  always #5 aclk = ~aclk;
  // count array strobes and keep the first program target and the last erase target
  always @(posedge aclk) begin
    if (flash_we) begin
      if (n_we == 0) begin
        first_a <= flash_addr;
        first_d <= {8'h00, flash_wdata};
      end
      n_we <= n_we + 1;
    end
    if (flash_erase) begin
      n_er <= n_er + 1;
      er_a <= flash_addr;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // axi write: each channel released once taken, bready held until bvalid
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rdat = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic tw(input logic h, input logic [23:0] ea, input logic [15:0] d);
    @(posedge aclk);
    go <= 1'b1;
    go_high <= h;
    go_ea <= ea;
    go_data <= d;
    @(posedge aclk);
    go <= 1'b0;
    do @(posedge aclk); while (!tbl_wr_done);
  endtask : tw
  task automatic unlock_and_start(input logic [31:0] ctl);
    int n = 0;
    wr(fsp_pkg::OFF_UNLOCK_KEY, 32'h00000055);
    wr(fsp_pkg::OFF_UNLOCK_KEY, 32'h000000AA);
    wr(fsp_pkg::OFF_OP_CONTROL, ctl);
    while (!flash_busy && n < 8) begin
      @(posedge aclk);
      n++;
    end
    while (flash_busy) @(posedge aclk);
  endtask : unlock_and_start
  task automatic t_regs;
    rd(fsp_pkg::OFF_OP_CONTROL);
    check(rdat, 32'h00000000);
    wr(fsp_pkg::OFF_ADDR_LOW, 32'h0000BEEF);
    check(32'(rsp), 32'(fsp_pkg::RESP_OKAY));
    wr(fsp_pkg::OFF_ADDR_UPPER, 32'h0000005A);
    rd(fsp_pkg::OFF_ADDR_LOW);
    check(rdat, 32'h0000BEEF);
    rd(fsp_pkg::OFF_ADDR_UPPER);
    check(rdat, 32'h0000005A);
    wr(8'h20, 32'h00000000);
    check(32'(rsp), 32'(fsp_pkg::RESP_SLVERR));
    wr(fsp_pkg::OFF_UNLOCK_KEY, 32'h00000055);
    rd(fsp_pkg::OFF_UNLOCK_KEY);
    check(rdat, 32'h00000000);
    rd(8'h20);
    check(32'(rsp), 32'(fsp_pkg::RESP_SLVERR));
  endtask : t_regs
  task automatic t_refuse;
    wr(fsp_pkg::OFF_OP_CONTROL, 32'h00008000);
    rd(fsp_pkg::OFF_STATUS);
    check(32'(rdat[2]), 32'h00000001);
    wr(fsp_pkg::OFF_UNLOCK_KEY, 32'h00000055);
    wr(fsp_pkg::OFF_UNLOCK_KEY, 32'h000000AA);
    rd(fsp_pkg::OFF_STATUS);
    check(32'(rdat[3]), 32'h00000001);
    wr(fsp_pkg::OFF_ADDR_LOW, 32'h00000000);
    wr(fsp_pkg::OFF_OP_CONTROL, 32'h00008000);
    rd(fsp_pkg::OFF_STATUS);
    check(32'(rdat[2]), 32'h00000001);
    check(32'(n_we + n_er), 32'h00000000);
  endtask : t_refuse
  // ascending fill of one 32-word row, one high write per eight words
  task automatic t_load;
    for (int i = 0; i < 32; i++) begin
      if (i % 8 == 0) tw(1'b1, 24'h012340 + 24'(2 * i), 16'h00C0 + 16'(i));
      tw(1'b0, 24'h012340 + 24'(2 * i), 16'hA500 + 16'(i));
    end
    rd(fsp_pkg::OFF_ADDR_LOW);
    check(rdat, 32'h0000237E);
    rd(fsp_pkg::OFF_ADDR_UPPER);
    check(rdat, 32'h00000001);
    rd(fsp_pkg::OFF_STATUS);
    check(32'(rdat[9:4]), 32'h00000020);
    check(32'(rdat[14:12]), 32'h00000004);
  endtask : t_load
  task automatic t_program;
    unlock_and_start(32'h00008000);
    check(32'(n_we), 32'h00000020);
    check(32'(first_a), 32'h00012340);
    check(32'(first_d[15:0]), 32'h0000A500);
    rd(fsp_pkg::OFF_OP_CONTROL);
    check(32'(rdat[15]), 32'h00000000);
  endtask : t_program
  task automatic t_erase;
    unlock_and_start(32'h00008040);
    check(32'(n_er), 32'h00000001);
    check(32'(er_a), 32'h00012340);
    check(32'(n_we), 32'h00000020);
  endtask : t_erase
  task automatic report_and_stop;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  // main sequence after eight reset cycles
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_refuse();
    t_load();
    t_program();
    t_erase();
    report_and_stop();
  end
  // watchdog well beyond the fewer than two thousand cycles the run needs
  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    report_and_stop();
  end
endmodule : flash_self_program_sequencer_tb
